// ===== cdsp_host_model.sv
/*
 * Host serial port model: receives framed words from the device and sends
 * framed words to it, both clocked from the device's shift clock.
 * Assumes the device changes its link outputs on serial_clk rises.
 */
`timescale 1ns/100ps
`default_nettype none
module cdsp_host_model
	import cdsp_pkg::*;
(
	// Link from device
	input  wire logic serial_clk,
	input  wire logic serial_out_line,
	input  wire logic out_frame_pulse,
	// Link to device
	output wire logic serial_in_line,
	output wire logic in_frame_pulse
);
	logic [WORD_W-1:0] rx_sh;
	int                rx_cnt  = 0;
	logic [WORD_W-1:0] rxq[$];
	logic [WORD_W-1:0] tx_word;
	int                tx_pos  = 0;
	int                tx_req  = 0;
	int                tx_ack  = 0;
	logic              line_q  = 1'h0;
	logic              frame_q = 1'h0;

	// One process owns the outgoing pins; send only posts a request
	assign serial_in_line = line_q;
	assign in_frame_pulse = frame_q;

	// Receive on falls of the supplied clock: frame, then MSB first
	always @(negedge serial_clk) begin
		if (rx_cnt > 0) begin
			rx_sh = {rx_sh[WORD_W-2:0], serial_out_line};
			rx_cnt = rx_cnt - 1;
			if (rx_cnt == 0)
				rxq.push_back(rx_sh);
		end else if (out_frame_pulse === 1'h1)
			rx_cnt = WORD_W;
	end

	// One word with its own frame, one clock before the MSB
	always @(posedge serial_clk) begin
		if (tx_pos > 0) begin
			frame_q <= 1'h0;
			line_q  <= tx_word[tx_pos-1];
			tx_pos = tx_pos - 1;
			if (tx_pos == 0)
				tx_ack = tx_ack + 1;
		end else if (tx_req != tx_ack) begin
			frame_q <= 1'h1;
			tx_pos = WORD_W;
		end else begin
			// Idle line toggles so a stale bit never passes for data
			line_q <= ~line_q;
		end
	end

	// Returns once the last bit is on the line; a next word may frame at once
	task automatic send(input logic [WORD_W-1:0] w);
		tx_word = w;
		tx_req  = tx_req + 1;
		wait (tx_ack == tx_req);
	endtask : send
endmodule : cdsp_host_model
`default_nettype wire

// ===== cdsp_pkg.sv
/*
 * Shared constants and types for the codec serial port block.
 * Assumes a single 40 MHz system clock; all link timing derives from it.
 */
`default_nettype none
package cdsp_pkg;
	localparam int WORD_W         = 16;
	localparam int SYS_CLK_HZ     = 40_000_000;
	localparam int SCLK_HALF_CYC  = 4;     // System cycles per half shift clock
	localparam int SAMPLE_SCLKS   = 256;   // Shift clocks per sample period
	localparam int BIT_CNT_W      = 4;
	localparam int DEV_ADDR_W     = 2;
	localparam int MAX_DEVICES    = 4;
	// Control word layout
	localparam int CTRL_FLAG_BIT  = 15;
	localparam int ADDR_LSB       = 11;
	localparam int SW_RESET_BIT   = 1;
	localparam int DATA_MODE_BIT  = 0;
	// Values after reset
	localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;
	localparam logic              MODE_RST  = 1'b0;   // Control mode
	localparam logic [1:0]        NEED_RST  = 2'h0;

	// One sample pair, channel 0 then channel 1
	typedef struct packed {
		logic [WORD_W-1:0] ch1;
		logic [WORD_W-1:0] ch0;
	} cdsp_pair_t;

	typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_SHIFT} cdsp_tx_st_t;
	typedef enum logic       {RX_IDLE, RX_SHIFT} cdsp_rx_st_t;
endpackage : cdsp_pkg
`default_nettype wire

// ===== cdsp_serial_port.sv
/*
 * Codec serial port: shift clock source, framed 16-bit transmit and receive,
 * control/data mode handling and cascade pass-through.
 * Assumes the host clocks both directions from serial_clk and that
 * serial_in_line and in_frame_pulse arrive from outside this clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module cdsp_serial_port
	import cdsp_pkg::*;
#(
	parameter int HALF_CYC  = SCLK_HALF_CYC,
	parameter int SAMPLE_SC = SAMPLE_SCLKS,
	parameter int DEV_ADDR  = 0
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       srst,
	// Converter side
	input  wire cdsp_pair_t adc_pair,
	output cdsp_pair_t      dac_pair,
	output logic            dac_valid,
	output logic [WORD_W-1:0] ctrl_word,
	output logic            ctrl_valid,
	output logic            data_mode,
	// Link pins
	input  wire logic       port_enable_pin,
	output logic            serial_clk,
	output logic            serial_out_line,
	output logic            out_frame_pulse,
	input  wire logic       serial_in_line,
	input  wire logic       in_frame_pulse
);
	localparam int CNT_W = $clog2(HALF_CYC + 1);
	localparam int SMP_W = $clog2(SAMPLE_SC + 1);
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(WORD_W - 1);
	localparam logic [DEV_ADDR_W-1:0] MY_ADDR = DEV_ADDR_W'(DEV_ADDR);

	// Input synchronisers, first stage read only by second
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	logic       en_s, din_s, fin_s;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sync1_ff <= 3'h0;
			sync2_ff <= 3'h0;
		end else begin
			sync1_ff <= {port_enable_pin, serial_in_line, in_frame_pulse};
			sync2_ff <= sync1_ff;
		end
	end
	assign {en_s, din_s, fin_s} = sync2_ff;

	// Shift clock divider; sample period counter in shift clocks
	logic [CNT_W-1:0] div_ff, nxt_div;
	logic [SMP_W-1:0] smp_ff, nxt_smp;
	logic             sclk_ff, nxt_sclk;
	logic             sclk_rise, sclk_fall, tick;
	assign sclk_rise = en_s && (div_ff == CNT_W'(HALF_CYC - 1)) && !sclk_ff;
	assign sclk_fall = en_s && (div_ff == CNT_W'(HALF_CYC - 1)) && sclk_ff;
	assign tick      = sclk_rise && (smp_ff == '0);

	// Clock runs continuously while the port is enabled, keeping every chained device in phase
	always_comb begin
		nxt_div  = div_ff;
		nxt_sclk = sclk_ff;
		nxt_smp  = smp_ff;
		if (!en_s) begin
			nxt_div  = '0;
			nxt_sclk = 1'b0;
		end else if (div_ff == CNT_W'(HALF_CYC - 1)) begin
			nxt_div  = '0;
			nxt_sclk = !sclk_ff;
		end else begin
			nxt_div = CNT_W'(div_ff + 1'b1);
		end
		if (sclk_rise) begin
			nxt_smp = (smp_ff == SMP_W'(SAMPLE_SC - 1)) ? '0 : SMP_W'(smp_ff + 1'b1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			div_ff  <= '0;
			sclk_ff <= 1'b0;
			smp_ff  <= '0;
		end else begin
			div_ff  <= nxt_div;
			sclk_ff <= nxt_sclk;
			smp_ff  <= nxt_smp;
		end
	end
	assign serial_clk = sclk_ff;

	// Receive path: frame seen on a falling edge, 16 bits follow
	cdsp_rx_st_t          rx_st_ff, nxt_rx_st;
	logic [BIT_CNT_W-1:0] rx_cnt_ff, nxt_rx_cnt;
	logic                 rx_shift, rx_done, rx_done_q;
	logic [WORD_W-1:0]    rx_word;
	always_comb begin
		nxt_rx_st  = rx_st_ff;
		nxt_rx_cnt = rx_cnt_ff;
		rx_shift   = 1'b0;
		if (sclk_fall) begin
			case (rx_st_ff)
				RX_IDLE: begin
					if (fin_s) begin
						nxt_rx_st  = RX_SHIFT;
						nxt_rx_cnt = '0;
					end
				end
				RX_SHIFT: begin
					rx_shift   = 1'b1;
					nxt_rx_cnt = BIT_CNT_W'(rx_cnt_ff + 1'b1);
					if (rx_cnt_ff == LAST_BIT) begin
						// A frame during the last bit starts the next word
						nxt_rx_st = fin_s ? RX_SHIFT : RX_IDLE;
						nxt_rx_cnt = '0;
					end
				end
				default: nxt_rx_st = RX_IDLE;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_st_ff  <= RX_IDLE;
			rx_cnt_ff <= '0;
			rx_done_q <= 1'b0;
		end else begin
			rx_st_ff  <= nxt_rx_st;
			rx_cnt_ff <= nxt_rx_cnt;
			rx_done_q <= rx_shift && (rx_cnt_ff == LAST_BIT);
		end
	end
	// Decode one cycle after the last shift, when the word is complete
	assign rx_done = rx_done_q;

	cdsp_shifter #(.W(WORD_W)) u_rx_sh (
		.sys_clk (sys_clk),
		.srst    (srst),
		.load    (1'b0),
		.shift   (rx_shift),
		.par_in  (WORD_RST),
		.ser_in  (din_s),
		.par_out (rx_word),
		.ser_out ()
	);

	// Word decode: control, sample or pass-through
	logic              mode_ff, nxt_mode;
	logic              dcnt_ff, nxt_dcnt;
	cdsp_pair_t        dac_ff, nxt_dac;
	logic              dvld_ff, nxt_dvld;
	logic [WORD_W-1:0] cw_ff, nxt_cw;
	logic              cvld_ff, nxt_cvld;
	logic [WORD_W-1:0] fwd_ff, nxt_fwd;
	logic              fwd_pend_ff, nxt_fwd_pend;
	logic [1:0]        need_ff, nxt_need;
	logic              fwd_take, smp_take;
	logic              is_ctrl, is_mine;
	assign is_ctrl = rx_word[CTRL_FLAG_BIT];
	assign is_mine = rx_word[ADDR_LSB +: DEV_ADDR_W] == MY_ADDR;

	always_comb begin
		nxt_mode     = mode_ff;
		nxt_dcnt     = dcnt_ff;
		nxt_dac      = dac_ff;
		nxt_dvld     = 1'b0;
		nxt_cw       = cw_ff;
		nxt_cvld     = 1'b0;
		nxt_fwd      = fwd_ff;
		nxt_fwd_pend = fwd_pend_ff && !fwd_take;
		nxt_need     = need_ff;
		if (smp_take) begin
			nxt_need = need_ff[0] ? {need_ff[1], 1'b0} : 2'h0;
		end
		// Two samples each period, none while in control mode
		if (tick) begin
			nxt_need = mode_ff ? 2'h3 : NEED_RST;
			nxt_dcnt = 1'b0;
		end
		if (rx_done) begin
			if (is_ctrl && is_mine) begin
				nxt_cw   = rx_word;
				nxt_cvld = 1'b1;
				// Software reset returns to control mode
				nxt_mode = rx_word[SW_RESET_BIT] ? MODE_RST : rx_word[DATA_MODE_BIT];
			end else if (!is_ctrl && mode_ff && (dcnt_ff == 1'b0)) begin
				nxt_dac.ch0 = rx_word;
				nxt_dcnt    = 1'b1;
			end else if (!is_ctrl && mode_ff && !tick && (dcnt_ff == 1'b1)) begin
				nxt_dac.ch1 = rx_word;
				nxt_dvld    = 1'b1;
				nxt_dcnt    = 1'b0;
			end else begin
				// Words for later devices go downstream; one word of slack
				nxt_fwd      = rx_word;
				nxt_fwd_pend = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mode_ff     <= MODE_RST;
			dcnt_ff     <= 1'b0;
			dac_ff      <= '0;
			dvld_ff     <= 1'b0;
			cw_ff       <= WORD_RST;
			cvld_ff     <= 1'b0;
			fwd_ff      <= WORD_RST;
			fwd_pend_ff <= 1'b0;
			need_ff     <= NEED_RST;
		end else begin
			mode_ff     <= nxt_mode;
			dcnt_ff     <= nxt_dcnt;
			dac_ff      <= nxt_dac;
			dvld_ff     <= nxt_dvld;
			cw_ff       <= nxt_cw;
			cvld_ff     <= nxt_cvld;
			fwd_ff      <= nxt_fwd;
			fwd_pend_ff <= nxt_fwd_pend;
			need_ff     <= nxt_need;
		end
	end
	assign dac_pair   = dac_ff;
	assign dac_valid  = dvld_ff;
	assign ctrl_word  = cw_ff;
	assign ctrl_valid = cvld_ff;
	assign data_mode  = mode_ff;

	// Transmit path, driven on rising edges: frame, then 16 bits
	cdsp_tx_st_t          tx_st_ff, nxt_tx_st;
	logic [BIT_CNT_W-1:0] tx_cnt_ff, nxt_tx_cnt;
	logic                 ofs_ff, nxt_ofs;
	logic                 obit_ff, nxt_obit;
	logic                 tx_load, tx_shift, tx_msb;
	logic [WORD_W-1:0]    tx_src;
	// Samples go first; forwarded words fill the rest of the period
	assign tx_src   = need_ff[0] ? adc_pair.ch0 : need_ff[1] ? adc_pair.ch1 : fwd_ff;
	assign tx_load  = sclk_rise && !tick && (tx_st_ff == TX_IDLE) && (|need_ff || fwd_pend_ff);
	assign smp_take = tx_load && |need_ff;
	assign fwd_take = tx_load && !(|need_ff);

	always_comb begin
		nxt_tx_st  = tx_st_ff;
		nxt_tx_cnt = tx_cnt_ff;
		nxt_ofs    = ofs_ff;
		nxt_obit   = obit_ff;
		tx_shift   = 1'b0;
		if (sclk_rise) begin
			case (tx_st_ff)
				TX_IDLE: begin
					nxt_obit = 1'b0;
					nxt_ofs  = tx_load;
					if (tx_load) begin
						nxt_tx_st = TX_FRAME;
					end
				end
				TX_FRAME: begin
					// MSB one clock after the frame
					nxt_ofs    = 1'b0;
					nxt_obit   = tx_msb;
					tx_shift   = 1'b1;
					nxt_tx_cnt = BIT_CNT_W'(1);
					nxt_tx_st  = TX_SHIFT;
				end
				TX_SHIFT: begin
					nxt_obit   = tx_msb;
					tx_shift   = 1'b1;
					nxt_tx_cnt = BIT_CNT_W'(tx_cnt_ff + 1'b1);
					if (tx_cnt_ff == LAST_BIT) begin
						nxt_tx_st = TX_IDLE;
					end
				end
				default: nxt_tx_st = TX_IDLE;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_st_ff  <= TX_IDLE;
			tx_cnt_ff <= '0;
			ofs_ff    <= 1'b0;
			obit_ff   <= 1'b0;
		end else begin
			tx_st_ff  <= nxt_tx_st;
			tx_cnt_ff <= nxt_tx_cnt;
			ofs_ff    <= nxt_ofs;
			obit_ff   <= nxt_obit;
		end
	end
	assign out_frame_pulse = ofs_ff;
	assign serial_out_line = obit_ff;

	cdsp_shifter #(.W(WORD_W)) u_tx_sh (
		.sys_clk (sys_clk),
		.srst    (srst),
		.load    (tx_load),
		.shift   (tx_shift),
		.par_in  (tx_src),
		.ser_in  (1'b0),
		.par_out (),
		.ser_out (tx_msb)
	);

	// Checks on the link timing and modes
	int unsigned hi_cnt;
	int unsigned bits_h;
	logic [WORD_W-1:0] held_h;
	always_ff @(posedge sys_clk) begin
		hi_cnt <= ofs_ff ? hi_cnt + 1 : 0;
		if (tx_load) held_h <= tx_src;
		if (tx_st_ff == TX_FRAME) bits_h <= 0;
		else if (sclk_rise && tx_st_ff == TX_SHIFT) bits_h <= bits_h + 1;
	end
	sequence frame_end_s;
		$fell(out_frame_pulse);
	endsequence
	sequence word_end_s;
		$past(tx_st_ff) == TX_SHIFT && tx_st_ff == TX_IDLE;
	endsequence

	frame_width_a: assert property (@(posedge sys_clk) disable iff (srst)
		frame_end_s |-> $past(hi_cnt) == 2 * HALF_CYC - 1) else $error("frame pulse width wrong");
	word_bits_a: assert property (@(posedge sys_clk) disable iff (srst)
		word_end_s |-> bits_h == WORD_W - 1) else $error("word is not sixteen bits");
	msb_first_a: assert property (@(posedge sys_clk) disable iff (srst)
		frame_end_s |-> serial_out_line == held_h[WORD_W-1]) else $error("MSB not after frame");
	frame_on_rise_a: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(out_frame_pulse) |-> $past(sclk_rise)) else $error("frame off rising edge");
	reset_ctrl_a: assert property (@(posedge sys_clk)
		srst |=> !data_mode) else $error("not in control mode after reset");
	no_samples_a: assert property (@(posedge sys_clk) disable iff (srst)
		tick && !mode_ff |=> need_ff == 2'h0) else $error("samples sent in control mode");
	two_words_a: assert property (@(posedge sys_clk) disable iff (srst)
		tick && mode_ff |=> need_ff == 2'h3) else $error("sample pair not requested");
	frame_then_word_a: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(out_frame_pulse) |-> ##[1:20] tx_st_ff == TX_SHIFT) else $error("frame without word");
	dac_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
		dac_valid |=> !dac_valid) else $error("dac valid not one cycle");
endmodule : cdsp_serial_port
`default_nettype wire

// ===== cdsp_shifter.sv
/*
 * Word shift register, MSB first, with parallel load and parallel view.
 * Assumes load and shift are one-cycle enables from the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module cdsp_shifter
	import cdsp_pkg::*;
#(
	parameter int W = WORD_W
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         srst,
	// Control
	input  wire logic         load,
	input  wire logic         shift,
	input  wire logic [W-1:0] par_in,
	input  wire logic         ser_in,
	// Results
	output logic      [W-1:0] par_out,
	output logic              ser_out
);
	logic [W-1:0] word_ff;
	logic [W-1:0] nxt_word;

	// Load wins over shift
	always_comb begin
		nxt_word = word_ff;
		if (load) begin
			nxt_word = par_in;
		end else if (shift) begin
			nxt_word = {word_ff[W-2:0], ser_in};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			word_ff <= '0;
		end else begin
			word_ff <= nxt_word;
		end
	end

	assign par_out = word_ff;
	assign ser_out = word_ff[W-1];
endmodule : cdsp_shifter
`default_nettype wire

// ===== tb_top.sv
/*
 * Self-checking bench for the codec serial port against a host model.
 * Assumes a 40 MHz sys_clk and a shortened sample period of 64 shift clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import cdsp_pkg::*;
();
	localparam int SMP = 64;
	localparam int PER = SMP * 2 * SCLK_HALF_CYC; // Sys cycles per sample period
	logic              sys_clk = 1'h0, srst = 1'h1, port_enable_pin = 1'h1;
	cdsp_pair_t        adc_pair = '0, dac_pair;
	logic              dac_valid, ctrl_valid, data_mode, serial_clk;
	logic              serial_out_line, out_frame_pulse, serial_in_line, in_frame_pulse;
	logic [WORD_W-1:0] ctrl_word, w0, w1, fw;
	int                n_fail = 0, checked = 0, cyc = 0, n_dac = 0, n_ctrl = 0, k;
	integer            seed = 32'h2B5C;

	always #12.5 sys_clk = ~sys_clk;

	cdsp_serial_port #(.HALF_CYC(SCLK_HALF_CYC), .SAMPLE_SC(SMP), .DEV_ADDR(0)) dut (
		.sys_clk(sys_clk), .srst(srst), .adc_pair(adc_pair), .dac_pair(dac_pair),
		.dac_valid(dac_valid), .ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid),
		.data_mode(data_mode), .port_enable_pin(port_enable_pin), .serial_clk(serial_clk),
		.serial_out_line(serial_out_line), .out_frame_pulse(out_frame_pulse),
		.serial_in_line(serial_in_line), .in_frame_pulse(in_frame_pulse));

	cdsp_host_model host (.serial_clk(serial_clk), .serial_out_line(serial_out_line),
		.out_frame_pulse(out_frame_pulse), .serial_in_line(serial_in_line),
		.in_frame_pulse(in_frame_pulse));

	// Pulse counters and hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (dac_valid === 1'h1)
			n_dac <= n_dac + 1;
		if (ctrl_valid === 1'h1)
			n_ctrl <= n_ctrl + 1;
		if (cyc == 40000) begin
			n_fail = n_fail + 1;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Control word: flag, address, reset and mode bits
	function automatic logic [WORD_W-1:0] ctl(input logic [1:0] a, input logic [1:0] b);
		return {1'h1, 2'h0, a, 9'h000, b};
	endfunction : ctl

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wait_cyc

	// Bounded waits on the host queue and on a device frame
	task automatic wait_rx(input int n);
		for (int i = 0; i < 3 * PER && host.rxq.size() < n; i++)
			@(posedge sys_clk);
	endtask : wait_rx

	task automatic wait_frame();
		for (int i = 0; i < 2 * PER && out_frame_pulse !== 1'h1; i++)
			@(posedge sys_clk);
	endtask : wait_frame

	// Highs of the shift clock over 64 sys cycles
	task automatic cnt_high(output int n);
		n = 0;
		repeat (64) begin
			@(posedge sys_clk);
			n = n + (serial_clk === 1'h1);
		end
	endtask : cnt_high

	// Main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		chk("clk_in_reset", 16'(serial_clk), 16'h0000);
		chk("mode_at_reset", 16'(data_mode), 16'h0000);
		srst <= 1'h0;
		wait_cyc(2 * PER);
		chk("words_in_ctrl_mode", 16'(host.rxq.size()), 16'h0000);
		cnt_high(k);
		chk("clk_high_count", 16'(k), 16'h0020);
		port_enable_pin <= 1'h0;
		wait_cyc(8);
		cnt_high(k);
		chk("clk_when_disabled", 16'(k), 16'h0000);
		port_enable_pin <= 1'h1;
		// Corner samples first: lone MSB and lone LSB
		w0 = 16'h8000;
		w1 = 16'h0001;
		adc_pair <= {w1, w0};
		wait_cyc(16);
		host.send(ctl(2'h0, 2'h1));
		wait_cyc(8);
		chk("ctrl_count", 16'(n_ctrl), 16'h0001);
		chk("ctrl_word", ctrl_word, ctl(2'h0, 2'h1));
		chk("data_mode_on", 16'(data_mode), 16'h0001);
		for (int p = 0; p < 4; p++) begin
			wait_rx(2 * p + 2);
			chk("ch0_word", host.rxq[2*p], w0);
			chk("ch1_word", host.rxq[2*p+1], w1);
			w0 = 16'($random(seed));
			w1 = 16'($random(seed));
			adc_pair <= {w1, w0};
		end
		wait_cyc(50);
		k = host.rxq.size();
		wait_cyc(3 * PER);
		chk("words_in_3_periods", 16'(host.rxq.size() - k), 16'h0006);
		// Two data words after the device frame, as a looped-back host would
		wait_frame();
		w0 = 16'($random(seed)) & 16'h7FFF;
		w1 = 16'h7FFF;
		host.send(w0);
		host.send(w1);
		wait_cyc(8);
		chk("dac_count", 16'(n_dac), 16'h0001);
		chk("dac_ch0", dac_pair.ch0, w0);
		chk("dac_ch1", dac_pair.ch1, w1);
		// Word for the last device in a chain is passed on
		k = host.rxq.size();
		fw = ctl(2'h3, 2'h2);
		wait_frame();
		host.send(fw);
		wait_rx(k + 5);
		k = 0;
		for (int i = 0; i < host.rxq.size(); i++)
			k = k + (host.rxq[i] === fw);
		chk("forwarded_word", 16'(k), 16'h0001);
		chk("ctrl_other_addr", 16'(n_ctrl), 16'h0001);
		host.send(ctl(2'h0, 2'h2));
		wait_cyc(8);
		chk("mode_after_sw_reset", 16'(data_mode), 16'h0000);
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
